// ---- mpio_pkg.sv ----
// Constants and address map of the multi-port I/O block
package mpio_pkg;
  // Data-memory byte locations of the port registers
  localparam logic [7:0] MPIO_L_DATA_ADDR = 8'hd0;
  localparam logic [7:0] MPIO_L_CFG_ADDR = 8'hd1;
  localparam logic [7:0] MPIO_L_PIN_ADDR = 8'hd2;
  localparam logic [7:0] MPIO_G_DATA_ADDR = 8'hd4;
  localparam logic [7:0] MPIO_G_CFG_ADDR = 8'hd5;
  localparam logic [7:0] MPIO_G_PIN_ADDR = 8'hd6;
  localparam logic [7:0] MPIO_C_DATA_ADDR = 8'hd8;
  localparam logic [7:0] MPIO_C_CFG_ADDR = 8'hd9;
  localparam logic [7:0] MPIO_C_PIN_ADDR = 8'hda;
  localparam logic [7:0] MPIO_I_PIN_ADDR = 8'hdc;
  localparam logic [7:0] MPIO_D_DATA_ADDR = 8'hdd;
  // Values after reset
  localparam logic [7:0] MPIO_BIDIR_RESET = 8'h00;
  localparam logic [7:0] MPIO_D_RESET = 8'hff;
  // Special port bit positions
  localparam int MPIO_G_IRQ_BIT = 0;
  localparam int MPIO_G_ERR_BIT = 1;
  localparam int MPIO_G_CAPT_BIT = 2;
  localparam int MPIO_G_T1IO_BIT = 3;
  localparam int MPIO_G_SDO_BIT = 4;
  localparam int MPIO_G_SCK_BIT = 5;
  localparam int MPIO_G_SDI_BIT = 6;
  localparam int MPIO_G_OSC_BIT = 7;
  localparam int MPIO_G_IDLE_BIT = 6;
  localparam int MPIO_G_HALT_BIT = 7;
  localparam int MPIO_G_ALTSK_BIT = 6;
  localparam int MPIO_G_DLY_BIT = 7;
  // Special port bits that are general I/O
  localparam logic [7:0] MPIO_G_GPIO_MASK = 8'h3d;
  // Bits of special data register that are stored and read back; bits 6 and 7 read as zero
  localparam logic [7:0] MPIO_G_DATA_RD_MASK = 8'h3f;
  // Synchroniser depth, in clock cycles
  localparam int MPIO_SYNC_STAGES = 2;
endpackage : mpio_pkg

// ---- mpio_sync.sv ----
// Two-flop synchroniser for a bus of pin levels
module mpio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values: first stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : mpio_sync

// ---- mpio_top.sv ----
// Multi-port parallel I/O block with memory-mapped port registers
//
// Contract
// [R1] Config and data bits pick hi-Z, pull-up input, drive low, drive high.
// [R2] Each bidirectional port has config, data and pin-read byte locations.
// [R3] Wake port feeds wakeup on all pins; bits 4-7 feed timers two, three.
// [R4] Special port: bits 0,2-5 I/O, bit 6 input, bit 1 error output.
// [R5] Bit 7 is oscillator output, or an input whose rise ends halt.
// [R6] Special data bits 6 and 7 always read back as zero.
// [R7] Writing one to special data bit 7 requests halt.
// [R8] Writing one to special data bit 6 requests idle.
// [R9] Special config bit 6 selects the alternate serial clock phase.
// [R10] Special config bit 7 enables start-up delay after halt; code does so only when CRYSTAL_OPTION is 0.
// [R11] Special port carries serial, timer one and interrupt alternates.
// [R12] Analog port is eight input-only hi-Z pins shared with comparator.
// [R13] Software masks unbonded bits or uses single-bit accesses.
// [R14] Output-only port is eight bits and driven high during reset.
// [R15] Every register bit is settable, clearable, testable on its own.
// [R16] Reset clears bidirectional registers, leaving pins as hi-Z inputs.
// [R17] Pin levels pass two synchroniser flops before any use.
module mpio_top
#(
  parameter int WIDTH = 8,
  parameter bit CRYSTAL_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data-memory access
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [WIDTH-1:0] cpu_wdata,
  input wire logic [WIDTH-1:0] cpu_wmask,
  input wire logic cpu_rd,
  output logic [WIDTH-1:0] cpu_rdata,
  // Wake-capable port pins
  input wire logic [WIDTH-1:0] l_pin_in,
  output logic [WIDTH-1:0] l_pin_out,
  output logic [WIDTH-1:0] l_pin_oe,
  output logic [WIDTH-1:0] l_pullup_en,
  // Special port pins
  input wire logic [WIDTH-1:0] g_pin_in,
  output logic [WIDTH-1:0] g_pin_out,
  output logic [WIDTH-1:0] g_pin_oe,
  output logic [WIDTH-1:0] g_pullup_en,
  // General port pins
  input wire logic [WIDTH-1:0] c_pin_in,
  output logic [WIDTH-1:0] c_pin_out,
  output logic [WIDTH-1:0] c_pin_oe,
  output logic [WIDTH-1:0] c_pullup_en,
  // Analog-sharing input port pins
  input wire logic [WIDTH-1:0] i_pin_in,
  // Output-only port pins
  output logic [WIDTH-1:0] d_pin_out,
  // Supervisor and oscillator
  input wire logic supervisor_error,
  input wire logic osc_level,
  // Power mode and serial clock phase controls
  output logic halt_req,
  output logic idle_req,
  output logic halt_wake,
  output logic startup_delay_enable,
  output logic serial_alt_phase,
  // Alternate function taps
  output logic [WIDTH-1:0] multi_input_wakeup,
  output logic timer_two_input_a,
  output logic timer_two_input_b,
  output logic timer_three_input_a,
  output logic timer_three_input_b,
  output logic serial_data_in,
  output logic serial_clock_pin,
  output logic serial_data_out_pin,
  output logic timer_one_io,
  output logic timer_one_capture_in,
  output logic external_irq_in,
  output logic [WIDTH-1:0] analog_pin_level
);
  import mpio_pkg::*;
  default clocking cb_clk @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [WIDTH-1:0] l_sync, g_sync, c_sync, i_sync;
  logic [WIDTH-1:0] l_data_q, l_data_d, l_cfg_q, l_cfg_d;
  logic [WIDTH-1:0] g_data_q, g_data_d, g_cfg_q, g_cfg_d;
  logic [WIDTH-1:0] c_data_q, c_data_d, c_cfg_q, c_cfg_d;
  logic [WIDTH-1:0] d_data_q, d_data_d;
  logic [WIDTH-1:0] rdata_q, rdata_d;
  logic halt_q, halt_d, idle_q, idle_d;
  logic osc_prev_q, osc_prev_d, wake_q, wake_d;
  logic g_data_wr;
  // Merge masked write bits into a register
  function automatic logic [WIDTH-1:0] merge(
    input logic [WIDTH-1:0] old_v,
    input logic [WIDTH-1:0] new_v,
    input logic [WIDTH-1:0] mask
  );
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge
  // [R17] Pin synchronisers
  mpio_sync #(.WIDTH(WIDTH)) u_sync_l (.clk(clk), .rst_n(rst_n),
    .async_in(l_pin_in), .sync_out(l_sync));
  mpio_sync #(.WIDTH(WIDTH)) u_sync_g (.clk(clk), .rst_n(rst_n),
    .async_in(g_pin_in), .sync_out(g_sync));
  mpio_sync #(.WIDTH(WIDTH)) u_sync_c (.clk(clk), .rst_n(rst_n),
    .async_in(c_pin_in), .sync_out(c_sync));
  mpio_sync #(.WIDTH(WIDTH)) u_sync_i (.clk(clk), .rst_n(rst_n),
    .async_in(i_pin_in), .sync_out(i_sync));
  assign g_data_wr = cpu_wr && (cpu_addr == MPIO_G_DATA_ADDR);
  // Register writes and read mux
  always_comb begin
    l_data_d = l_data_q;
    l_cfg_d = l_cfg_q;
    g_data_d = g_data_q;
    g_cfg_d = g_cfg_q;
    c_data_d = c_data_q;
    c_cfg_d = c_cfg_q;
    d_data_d = d_data_q;
    // [R15] Masked writes give single-bit set and clear
    if (cpu_wr) begin
      unique case (cpu_addr)
        MPIO_L_DATA_ADDR: l_data_d = merge(l_data_q, cpu_wdata, cpu_wmask);
        MPIO_L_CFG_ADDR: l_cfg_d = merge(l_cfg_q, cpu_wdata, cpu_wmask);
        MPIO_G_DATA_ADDR: g_data_d = merge(g_data_q, cpu_wdata,
          cpu_wmask & MPIO_G_DATA_RD_MASK);
        MPIO_G_CFG_ADDR: g_cfg_d = merge(g_cfg_q, cpu_wdata, cpu_wmask);
        MPIO_C_DATA_ADDR: c_data_d = merge(c_data_q, cpu_wdata, cpu_wmask);
        MPIO_C_CFG_ADDR: c_cfg_d = merge(c_cfg_q, cpu_wdata, cpu_wmask);
        MPIO_D_DATA_ADDR: d_data_d = merge(d_data_q, cpu_wdata, cpu_wmask);
        default: ;
      endcase
    end
    rdata_d = rdata_q;
    // [R2] Three locations per bidirectional port
    if (cpu_rd) begin
      unique case (cpu_addr)
        MPIO_L_DATA_ADDR: rdata_d = l_data_q;
        MPIO_L_CFG_ADDR: rdata_d = l_cfg_q;
        MPIO_L_PIN_ADDR: rdata_d = l_sync;
        // [R6] Mode bits read as zero
        MPIO_G_DATA_ADDR: rdata_d = g_data_q & MPIO_G_DATA_RD_MASK;
        MPIO_G_CFG_ADDR: rdata_d = g_cfg_q;
        MPIO_G_PIN_ADDR: rdata_d = g_sync;
        MPIO_C_DATA_ADDR: rdata_d = c_data_q;
        MPIO_C_CFG_ADDR: rdata_d = c_cfg_q;
        MPIO_C_PIN_ADDR: rdata_d = c_sync;
        // [R12] Analog port read as plain input
        MPIO_I_PIN_ADDR: rdata_d = i_sync;
        MPIO_D_DATA_ADDR: rdata_d = d_data_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // Port registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // [R16] Bidirectional registers clear
      l_data_q <= MPIO_BIDIR_RESET;
      l_cfg_q <= MPIO_BIDIR_RESET;
      g_data_q <= MPIO_BIDIR_RESET;
      g_cfg_q <= MPIO_BIDIR_RESET;
      c_data_q <= MPIO_BIDIR_RESET;
      c_cfg_q <= MPIO_BIDIR_RESET;
      // [R14] Output port preset high
      d_data_q <= MPIO_D_RESET;
      rdata_q <= '0;
    end else begin
      l_data_q <= l_data_d;
      l_cfg_q <= l_cfg_d;
      g_data_q <= g_data_d;
      g_cfg_q <= g_cfg_d;
      c_data_q <= c_data_d;
      c_cfg_q <= c_cfg_d;
      d_data_q <= d_data_d;
      rdata_q <= rdata_d;
    end
  end

  // Mode requests and halt restart edge
  always_comb begin
    // [R7] Halt request on write of one
    halt_d = g_data_wr && cpu_wmask[MPIO_G_HALT_BIT]
      && cpu_wdata[MPIO_G_HALT_BIT];
    // [R8] Idle request on write of one
    idle_d = g_data_wr && cpu_wmask[MPIO_G_IDLE_BIT]
      && cpu_wdata[MPIO_G_IDLE_BIT];
    osc_prev_d = g_sync[MPIO_G_OSC_BIT];
    // [R5] Rising input edge ends halt
    wake_d = !CRYSTAL_OPTION && g_sync[MPIO_G_OSC_BIT] && !osc_prev_q;
  end

  // Register mode pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_q <= 1'b0;
      idle_q <= 1'b0;
      osc_prev_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      halt_q <= halt_d;
      idle_q <= idle_d;
      osc_prev_q <= osc_prev_d;
      wake_q <= wake_d;
    end
  end

  assign halt_req = halt_q;
  assign idle_req = idle_q;
  assign halt_wake = wake_q;
  assign cpu_rdata = rdata_q;
  assign d_pin_out = d_data_q;

  // [R1] Pin drive from config and data
  assign l_pin_oe = l_cfg_q;
  assign l_pin_out = l_data_q;
  assign l_pullup_en = ~l_cfg_q & l_data_q;
  assign c_pin_oe = c_cfg_q;
  assign c_pin_out = c_data_q;
  assign c_pullup_en = ~c_cfg_q & c_data_q;

  // [R4] Special port drive per bit
  always_comb begin
    g_pin_oe = g_cfg_q & MPIO_G_GPIO_MASK;
    g_pin_out = g_data_q & MPIO_G_GPIO_MASK;
    g_pullup_en = ~g_cfg_q & g_data_q & MPIO_G_GPIO_MASK;
    // Error output drives low only while an error stands
    g_pin_oe[MPIO_G_ERR_BIT] = supervisor_error;
    g_pin_out[MPIO_G_ERR_BIT] = 1'b0;
    // [R5] Oscillator output under crystal option
    g_pin_oe[MPIO_G_OSC_BIT] = CRYSTAL_OPTION;
    g_pin_out[MPIO_G_OSC_BIT] = CRYSTAL_OPTION && osc_level;
  end

  // [R9] Alternate serial clock phase
  assign serial_alt_phase = g_cfg_q[MPIO_G_ALTSK_BIT];
  // [R10] Start-up delay only with resistor-capacitor clock
  assign startup_delay_enable = !CRYSTAL_OPTION && g_cfg_q[MPIO_G_DLY_BIT];

  // [R3] Wakeup and timer two, three inputs
  assign multi_input_wakeup = l_sync;
  assign timer_two_input_a = l_sync[4];
  assign timer_two_input_b = l_sync[5];
  assign timer_three_input_a = l_sync[6];
  assign timer_three_input_b = l_sync[7];
  // [R11] Special port alternate inputs
  assign serial_data_in = g_sync[MPIO_G_SDI_BIT];
  assign serial_clock_pin = g_sync[MPIO_G_SCK_BIT];
  assign serial_data_out_pin = g_sync[MPIO_G_SDO_BIT];
  assign timer_one_io = g_sync[MPIO_G_T1IO_BIT];
  assign timer_one_capture_in = g_sync[MPIO_G_CAPT_BIT];
  assign external_irq_in = g_sync[MPIO_G_IRQ_BIT];
  assign analog_pin_level = i_sync;
  // Checks
  property p_pullup;
    (cpu_wr && cpu_addr == MPIO_L_DATA_ADDR && cpu_wmask == '1
      && l_cfg_q == '0) |=> l_pullup_en == $past(cpu_wdata);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong"); // [R1]
  property p_g_read_zero;
    (cpu_rd && cpu_addr == MPIO_G_DATA_ADDR) |=> (cpu_rdata[7:6] == 2'b00);
  endproperty
  a_g_read_zero: assert property (p_g_read_zero) // [R6]
    else $error("mode bits read nonzero");
  sequence s_halt_write;
    g_data_wr && cpu_wmask[MPIO_G_HALT_BIT] && cpu_wdata[MPIO_G_HALT_BIT];
  endsequence
  property p_halt;
    s_halt_write |=> halt_req ##1 (!halt_req || $past(halt_d));
  endproperty
  a_halt: assert property (p_halt) else $error("halt not pulsed"); // [R7]
  property p_idle;
    $rose(idle_req) |-> $past(g_data_wr && cpu_wmask[6] && cpu_wdata[6]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle without write"); // [R8]
  property p_alt_phase;
    (cpu_wr && cpu_addr == MPIO_G_CFG_ADDR && cpu_wmask[6])
      |=> serial_alt_phase == $past(cpu_wdata[6]);
  endproperty
  a_alt_phase: assert property (p_alt_phase) // [R9]
    else $error("phase bit not stored");
  property p_err_pin;
    g_pin_oe[1] == supervisor_error && !g_pin_out[1];
  endproperty
  a_err_pin: assert property (p_err_pin) else $error("error pin bad"); // [R4]
  property p_d_reset;
    $rose(rst_n) |-> d_pin_out == MPIO_D_RESET;
  endproperty
  a_d_reset: assert property (p_d_reset) // [R14]
    else $error("port D not high");
  property p_bidir_reset;
    $rose(rst_n) |-> (l_pin_oe == '0 && c_pin_oe == '0);
  endproperty
  a_bidir_reset: assert property (p_bidir_reset) // [R16]
    else $error("port not hi-Z after reset");
  property p_sync;
    $rose(rst_n) ##2 1'b1 |-> multi_input_wakeup == $past(l_pin_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("wakeup not synced"); // [R17]
endmodule : mpio_top

// ---- mpio_pins.sv ----
// Board-side model of one port's pins and their loads
module mpio_pins (
  // Clock
  input wire logic clk,
  // Device side of the pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  // External drivers on the board
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pin levels
  output logic [7:0] level
);
  logic [7:0] float_q = 8'h55;
  // Undriven pins wander every cycle
  always @(posedge clk) float_q <= ~float_q;
  // Device drive wins, then board, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) level[i] = pin_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pullup_en[i]) level[i] = 1'b1;
      else level[i] = float_q[i];
    end
  end
endmodule : mpio_pins

// ---- multi_port_io_block_test.sv ----
// Self-checking bench for the multi-port I/O block
module multi_port_io_block_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mpio_pkg::*;
  logic clk, rst_n, cpu_wr, cpu_rd, supervisor_error, osc_level;
  logic [7:0] cpu_addr, cpu_wdata, cpu_wmask, cpu_rdata, i_pin_in;
  logic [7:0] l_pin_in, l_pin_out, l_pin_oe, l_pullup_en;
  logic [7:0] g_pin_in, g_pin_out, g_pin_oe, g_pullup_en;
  logic [7:0] c_pin_in, c_pin_out, c_pin_oe, c_pullup_en;
  logic [7:0] d_pin_out, multi_input_wakeup, analog_pin_level, ext_en;
  logic halt_req, idle_req, halt_wake, startup_delay_enable;
  logic serial_alt_phase, timer_two_input_a, timer_two_input_b;
  logic timer_three_input_a, timer_three_input_b, serial_data_in;
  logic serial_clock_pin, serial_data_out_pin, timer_one_io;
  logic timer_one_capture_in, external_irq_in;
  logic [7:0] p_ext [3];
  logic [7:0] p_oe [3];
  logic [7:0] p_out [3];
  logic [7:0] p_pu [3];
  logic [31:0] seed = 32'h0000a00c;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [7:0] CFG_A [3] = '{MPIO_L_CFG_ADDR, MPIO_G_CFG_ADDR,
    MPIO_C_CFG_ADDR};
  localparam logic [7:0] DAT_A [3] = '{MPIO_L_DATA_ADDR, MPIO_G_DATA_ADDR,
    MPIO_C_DATA_ADDR};
  localparam logic [7:0] PIN_A [3] = '{MPIO_L_PIN_ADDR, MPIO_G_PIN_ADDR,
    MPIO_C_PIN_ADDR};

  // Design under test, oscillator pin used as plain input
  mpio_top #(.WIDTH(8), .CRYSTAL_OPTION(1'b0)) i_dut (.clk(clk),
    .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .l_pin_in(l_pin_in), .l_pin_out(l_pin_out),
    .l_pin_oe(l_pin_oe), .l_pullup_en(l_pullup_en), .g_pin_in(g_pin_in),
    .g_pin_out(g_pin_out), .g_pin_oe(g_pin_oe),
    .g_pullup_en(g_pullup_en), .c_pin_in(c_pin_in),
    .c_pin_out(c_pin_out), .c_pin_oe(c_pin_oe),
    .c_pullup_en(c_pullup_en), .i_pin_in(i_pin_in),
    .d_pin_out(d_pin_out), .supervisor_error(supervisor_error),
    .osc_level(osc_level), .halt_req(halt_req), .idle_req(idle_req),
    .halt_wake(halt_wake), .startup_delay_enable(startup_delay_enable),
    .serial_alt_phase(serial_alt_phase),
    .multi_input_wakeup(multi_input_wakeup),
    .timer_two_input_a(timer_two_input_a),
    .timer_two_input_b(timer_two_input_b),
    .timer_three_input_a(timer_three_input_a),
    .timer_three_input_b(timer_three_input_b),
    .serial_data_in(serial_data_in), .serial_clock_pin(serial_clock_pin),
    .serial_data_out_pin(serial_data_out_pin), .timer_one_io(timer_one_io),
    .timer_one_capture_in(timer_one_capture_in),
    .external_irq_in(external_irq_in),
    .analog_pin_level(analog_pin_level));
  // Board loads on the three bidirectional ports
  mpio_pins i_l (.clk(clk), .pin_out(l_pin_out), .pin_oe(l_pin_oe),
    .pullup_en(l_pullup_en), .ext_val(p_ext[0]), .ext_en(ext_en),
    .level(l_pin_in));
  mpio_pins i_g (.clk(clk), .pin_out(g_pin_out), .pin_oe(g_pin_oe),
    .pullup_en(g_pullup_en), .ext_val(p_ext[1]), .ext_en(ext_en),
    .level(g_pin_in));
  mpio_pins i_c (.clk(clk), .pin_out(c_pin_out), .pin_oe(c_pin_oe),
    .pullup_en(c_pullup_en), .ext_val(p_ext[2]), .ext_en(ext_en),
    .level(c_pin_in));
  // Port outputs gathered for indexed checks
  always_comb begin
    p_oe = '{l_pin_oe, g_pin_oe, c_pin_oe};
    p_out = '{l_pin_out, g_pin_out, c_pin_out};
    p_pu = '{l_pullup_en, g_pullup_en, c_pullup_en};
  end

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [7:0] msk(int k);
    return (k == 1) ? MPIO_G_GPIO_MASK : 8'hff;
  endfunction : msk

  function automatic logic [7:0] rdm(int k);
    return (k == 1) ? MPIO_G_DATA_RD_MASK : 8'hff;
  endfunction : rdm

  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d, logic [7:0] m);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wmask <= m;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(negedge clk);
    v = cpu_rdata;
  endtask : rd

  task automatic reset_check();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("d_out", d_pin_out, MPIO_D_RESET);
    for (int k = 0; k < 3; k++) begin
      chk("oe", p_oe[k], MPIO_BIDIR_RESET);
      chk("pullup", p_pu[k], MPIO_BIDIR_RESET);
    end
    @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset_check

  task automatic close_out();
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    logic [7:0] c, d, b, v, n;
    {rst_n, cpu_wr, cpu_rd, supervisor_error, osc_level} = 5'h00;
    {cpu_addr, cpu_wdata, cpu_wmask, i_pin_in, ext_en} = 40'h0;
    p_ext = '{8'h00, 8'h00, 8'h00};
    reset_check();
    repeat (4) for (int k = 0; k < 3; k++) begin
      c = rnd();
      d = rnd();
      v = rnd();
      b = 8'h01 << v[2:0];
      wr(CFG_A[k], c, 8'hff);
      wr(DAT_A[k], d, 8'hff);
      wr(DAT_A[k], 8'hff, b);
      d = d | b;
      @(negedge clk);
      chk("oe", p_oe[k] & msk(k), c & msk(k));
      chk("out", p_out[k] & msk(k), d & msk(k));
      chk("pullup", p_pu[k] & msk(k), ~c & d & msk(k));
      rd(CFG_A[k], v);
      chk("cfg_rd", v, c);
      rd(DAT_A[k], v);
      chk("dat_rd", v, d & rdm(k));
      wr(DAT_A[k], 8'h00, b);
      rd(DAT_A[k], v);
      chk("bit_clr", v, d & ~b & rdm(k));
    end
    for (int k = 0; k < 3; k++) begin
      wr(CFG_A[k], 8'h00, 8'hff);
      wr(DAT_A[k], 8'h00, 8'hff);
    end
    ext_en <= 8'hff;
    repeat (4) begin
      @(posedge clk);
      for (int k = 0; k < 3; k++) p_ext[k] <= rnd();
      i_pin_in <= rnd();
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("wake", multi_input_wakeup, p_ext[0]);
      chk("timers", {4'h0, timer_three_input_b, timer_three_input_a,
        timer_two_input_b, timer_two_input_a}, p_ext[0] >> 4);
      chk("g_alt", {2'b00, serial_data_in, serial_clock_pin,
        serial_data_out_pin, timer_one_io, timer_one_capture_in,
        external_irq_in}, {2'b00, p_ext[1][6:2], p_ext[1][0]});
      chk("analog", analog_pin_level, i_pin_in);
      for (int k = 0; k < 3; k++) begin
        rd(PIN_A[k], v);
        chk("pin_rd", v, p_ext[k]);
      end
      rd(MPIO_I_PIN_ADDR, v);
      chk("i_rd", v, i_pin_in);
    end
    @(posedge clk);
    p_ext[1] <= 8'h00;
    repeat (4) @(posedge clk);
    p_ext[1] <= 8'h80;
    n = 8'h00;
    repeat (6) begin
      @(negedge clk);
      n = n + {7'h00, halt_wake};
    end
    chk("halt_wake", n, 8'h01);
    for (int k = 6; k < 8; k++) begin
      wr(MPIO_G_DATA_ADDR, 8'hff, 8'h01 << k);
      @(negedge clk);
      chk("mode", {6'h00, halt_req, idle_req}, 8'h01 << (k - 6));
      @(negedge clk);
      chk("mode_end", {6'h00, halt_req, idle_req}, 8'h00);
    end
    wr(MPIO_G_CFG_ADDR, 8'hc0, 8'hc0);
    @(negedge clk);
    chk("g_cfg", {6'h00, startup_delay_enable, serial_alt_phase},
      8'h03);
    wr(MPIO_G_CFG_ADDR, 8'h00, 8'h80);
    @(negedge clk);
    chk("g_cfg", {6'h00, startup_delay_enable, serial_alt_phase},
      8'h01);
    @(posedge clk);
    supervisor_error <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("err_pin", {6'h00, g_pin_oe[1], g_pin_out[1]}, 8'h02);
    @(posedge clk);
    supervisor_error <= 1'b0;
    wr(8'h00, 8'hff, 8'hff);
    rd(8'h00, v);
    chk("unmapped", v, 8'h00);
    d = rnd() & 8'h7f;
    wr(MPIO_D_DATA_ADDR, d, 8'hff);
    @(negedge clk);
    chk("d_out", d_pin_out, d);
    for (int k = 0; k < 3; k++) wr(CFG_A[k], 8'hff, 8'hff);
    reset_check();
    // Config registers read back clear after a mid-run reset
    for (int k = 0; k < 3; k++) begin
      rd(CFG_A[k], v);
      chk("cfg_rst", v, MPIO_BIDIR_RESET);
    end
    close_out();
  end
endmodule : multi_port_io_block_test
